// ### src/erw_top.sv
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
module erw_top
   import erw_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [ERW_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 link_clk_i,
   input  wire logic                 ready_i,
   output logic                      bus_reference_clock_out_o,
   output logic                      cs_n_o,
   output logic                      rd_n_o,
   output logic                      wr_n_o
);
   // System clock domain: register slave
   logic [ERW_CTRL_W-1:0] ctrl;
   logic                  busy;
   logic                  req_tgl;
   erw_wcnt_t             last_wcnt;
   erw_wcnt_t             link_wcnt;
   logic                  done_pulse;
   logic [31:0]           rd_mux;

   wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_req   = bus_req & wb_we_i;
   wire hit_ctrl = wb_adr_i == ERW_ADR_CTRL;
   wire hit_go   = wb_adr_i == ERW_ADR_START;
   wire hit_stat = wb_adr_i == ERW_ADR_STATUS;
   wire wr_ctrl  = wr_req & hit_ctrl & ~busy;
   wire start    = wr_req & hit_go & wb_sel_i[0] & wb_dat_i[ERW_START_GO] & ~busy;

   wire [31:0] stat_word = {16'h0000, last_wcnt, 7'h00, busy};

   assign rd_mux = hit_ctrl ? {20'h00000, ctrl} :
                   hit_go   ? 32'h0000_0000 :
                   hit_stat ? stat_word :
                              32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= (bus_req & ~wb_we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // Configuration is frozen while a cycle runs so the link side sees stable words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= ERW_CTRL_RESET;
      end else if (wr_ctrl) begin
         if (wb_sel_i[0]) begin
            ctrl[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            ctrl[ERW_CTRL_W-1:8] <= wb_dat_i[ERW_CTRL_W-1:8];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy      <= 1'b0;
         req_tgl   <= 1'b0;
         last_wcnt <= ERW_WCNT_ZERO;
      end else begin
         if (start) begin
            busy    <= 1'b1;
            req_tgl <= ~req_tgl;
         end else if (done_pulse) begin
            busy <= 1'b0;
         end
         if (done_pulse) begin
            last_wcnt <= link_wcnt;
         end
      end
   end

   // Link clock domain: bus cycle sequencer
   logic       link_rst;
   logic       req_pulse;
   logic       done_tgl;
   logic       ref_q;
   logic       rdy_pin_q;
   logic       rdy_async;
   erw_state_e state;
   erw_acc_t   acc_cnt;
   erw_hld_t   hld_cnt;
   logic       cyc_pol;
   logic       cyc_async;
   logic       cyc_rdy_en;
   logic       cyc_write;
   erw_hld_t   cyc_hold;

   erw_sync u_rst_sync (
      .clk_i (link_clk_i),
      .rst_i (1'b0),
      .d_i   (rst_i),
      .q_o   (link_rst)
   );

   erw_pulse_sync u_req_sync (
      .clk_i   (link_clk_i),
      .rst_i   (link_rst),
      .tgl_i   (req_tgl),
      .pulse_o (req_pulse)
   );

   erw_pulse_sync u_done_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tgl_i   (done_tgl),
      .pulse_o (done_pulse)
   );

   // Extra stage for free-running ready
   erw_sync u_rdy_sync (
      .clk_i (link_clk_i),
      .rst_i (link_rst),
      .d_i   (ready_i),
      .q_o   (rdy_async)
   );

   // Synchronous ready is taken by the input register alone
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         rdy_pin_q <= 1'b0;
      end else begin
         rdy_pin_q <= ready_i;
      end
   end

   // Reference clock is the link clock divided by two; phases advance on its falling edge
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         ref_q <= 1'b0;
      end else begin
         ref_q <= ~ref_q;
      end
   end

   assign bus_reference_clock_out_o = ref_q;

   wire tick       = ref_q;
   wire rdy_raw    = cyc_async ? rdy_async : rdy_pin_q;
   wire rdy_active = cyc_pol ? rdy_raw : ~rdy_raw;
   wire acc_done   = acc_cnt == ERW_ACC_ZERO;
   wire hld_done   = hld_cnt == ERW_HLD_ZERO;
   wire wcnt_inc   = link_wcnt != ERW_WCNT_MAX;

   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         state      <= ERW_IDLE;
         acc_cnt    <= ERW_ACC_ZERO;
         hld_cnt    <= ERW_HLD_ZERO;
         link_wcnt  <= ERW_WCNT_ZERO;
         done_tgl   <= 1'b0;
         cyc_pol    <= 1'b0;
         cyc_async  <= 1'b0;
         cyc_rdy_en <= 1'b0;
         cyc_write  <= 1'b0;
         cyc_hold   <= ERW_HLD_ZERO;
         cs_n_o     <= 1'b1;
         rd_n_o     <= 1'b1;
         wr_n_o     <= 1'b1;
      end else begin
         case (state)
            ERW_IDLE: begin
               if (req_pulse) begin
                  cyc_rdy_en <= ctrl[ERW_CTRL_RDY_EN];
                  cyc_pol    <= ctrl[ERW_CTRL_POL_HI];
                  cyc_async  <= ctrl[ERW_CTRL_ASYNC];
                  cyc_write  <= ctrl[ERW_CTRL_WRITE];
                  cyc_hold   <= ctrl[ERW_CTRL_HLD_LSB +: ERW_HLD_W];
                  acc_cnt    <= ctrl[ERW_CTRL_ACC_LSB +: ERW_ACC_W];
                  link_wcnt  <= ERW_WCNT_ZERO;
                  cs_n_o     <= 1'b0;
                  rd_n_o     <= ctrl[ERW_CTRL_WRITE];
                  wr_n_o     <= ~ctrl[ERW_CTRL_WRITE];
                  state      <= ERW_ACCESS;
               end
            end
            ERW_ACCESS: begin
               if (tick) begin
                  if (!acc_done) begin
                     acc_cnt <= acc_cnt - ERW_ACC_ONE;
                  end else if (!cyc_rdy_en || (!cyc_async && rdy_active)) begin
                     rd_n_o  <= 1'b1;
                     wr_n_o  <= 1'b1;
                     hld_cnt <= cyc_hold;
                     state   <= ERW_HOLD;
                  end else begin
                     link_wcnt <= ERW_WCNT_ONE;
                     state     <= ERW_RDWAIT;
                  end
               end
            end
            ERW_RDWAIT: begin
               if (tick) begin
                  if (rdy_active) begin
                     rd_n_o  <= 1'b1;
                     wr_n_o  <= 1'b1;
                     hld_cnt <= cyc_hold;
                     state   <= ERW_HOLD;
                  end else if (wcnt_inc) begin
                     link_wcnt <= link_wcnt + ERW_WCNT_ONE;
                  end
               end
            end
            ERW_HOLD: begin
               if (tick) begin
                  if (!hld_done) begin
                     hld_cnt <= hld_cnt - ERW_HLD_ONE;
                  end else begin
                     cs_n_o   <= 1'b1;
                     done_tgl <= ~done_tgl;
                     state    <= ERW_IDLE;
                  end
               end
            end
            default: begin
               state <= ERW_IDLE;
            end
         endcase
      end
   end
endmodule : erw_top

// ### src/erw_pkg.sv
package erw_pkg;
   localparam int          ERW_ADR_W        = 4;
   localparam logic [3:0]  ERW_ADR_CTRL     = 4'h0;
   localparam logic [3:0]  ERW_ADR_START    = 4'h4;
   localparam logic [3:0]  ERW_ADR_STATUS   = 4'h8;

   localparam int          ERW_CTRL_RDY_EN  = 0;
   localparam int          ERW_CTRL_POL_HI  = 1;
   localparam int          ERW_CTRL_ASYNC   = 2;
   localparam int          ERW_CTRL_WRITE   = 3;
   localparam int          ERW_CTRL_ACC_LSB = 4;
   localparam int          ERW_ACC_W        = 5;
   localparam int          ERW_CTRL_HLD_LSB = 9;
   localparam int          ERW_HLD_W        = 2;
   localparam int          ERW_CTRL_W       = 12;
   localparam logic [11:0] ERW_CTRL_RESET   = 12'h002;

   localparam int          ERW_START_GO     = 0;
   localparam int          ERW_STAT_BUSY    = 0;
   localparam int          ERW_STAT_WC_LSB  = 8;
   localparam int          ERW_WCNT_W       = 8;

   typedef logic [ERW_ACC_W-1:0]  erw_acc_t;
   typedef logic [ERW_HLD_W-1:0]  erw_hld_t;
   typedef logic [ERW_WCNT_W-1:0] erw_wcnt_t;

   localparam erw_acc_t  ERW_ACC_ZERO  = 5'h00;
   localparam erw_acc_t  ERW_ACC_ONE   = 5'h01;
   localparam erw_hld_t  ERW_HLD_ZERO  = 2'h0;
   localparam erw_hld_t  ERW_HLD_ONE   = 2'h1;
   localparam erw_wcnt_t ERW_WCNT_ZERO = 8'h00;
   localparam erw_wcnt_t ERW_WCNT_ONE  = 8'h01;
   localparam erw_wcnt_t ERW_WCNT_MAX  = 8'hFF;

   typedef enum logic [1:0] {
      ERW_IDLE   = 2'b00,
      ERW_ACCESS = 2'b01,
      ERW_RDWAIT = 2'b10,
      ERW_HOLD   = 2'b11
   } erw_state_e;
endpackage : erw_pkg

// ### src/erw_sync.sv
module erw_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : erw_sync

// ### src/erw_pulse_sync.sv
module erw_pulse_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic tgl_i,
   output logic      pulse_o
);
   logic tgl_s;
   logic tgl_d;

   erw_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (tgl_i),
      .q_o   (tgl_s)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tgl_d <= 1'b0;
      end else begin
         tgl_d <= tgl_s;
      end
   end

   assign pulse_o = tgl_s ^ tgl_d;
endmodule : erw_pulse_sync

// ### test/erw_ready_model.sv
module erw_ready_model (
   input  wire logic       link_clk_i,
   input  wire logic       ref_clk_i,
   input  wire logic       strobe_n_i,
   input  wire logic       pol_hi_i,
   input  wire logic [3:0] dly_i,
   output logic            ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt   = 4'h0;
   logic       ref_q = 1'b0;
   logic       act;
   // Active from dly_i reference periods into the strobe until the strobe rises; with dly_i zero it is active at all times
   assign act     = (cnt >= dly_i);
   assign ready_o = pol_hi_i ? act : !act;
   always @(posedge link_clk_i) begin
      ref_q <= ref_clk_i;
      if (strobe_n_i) begin
         cnt <= 4'h0;
      end else if (ref_clk_i && !ref_q && cnt != 4'hF) begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule : erw_ready_model

// ### test/erw_top_chk.sv
module erw_top_chk (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        link_clk_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_ack_o,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        bus_reference_clock_out_o,
   input  wire logic        cs_n_o,
   input  wire logic        rd_n_o,
   input  wire logic        wr_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence strobe_s;
      !rd_n_o || !wr_n_o;
   endsequence
   ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i) req_s |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 0)
      else $error("read data without ack");
   strobe_excl_a: assert property (@(posedge link_clk_i) disable iff (rst_i) !(!rd_n_o && !wr_n_o))
      else $error("both strobes low");
   cs_cover_a: assert property (@(posedge link_clk_i) disable iff (rst_i) strobe_s |-> !cs_n_o)
      else $error("strobe outside chip select");
   cs_open_a: assert property (@(posedge link_clk_i) disable iff (rst_i) $fell(cs_n_o) |-> strobe_s)
      else $error("cycle opened without strobe");
   hold_after_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
      $rose(rd_n_o) || $rose(wr_n_o) |-> !cs_n_o) else $error("no hold after strobe");
   cs_close_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
      $rose(cs_n_o) |-> rd_n_o && wr_n_o) else $error("cycle closed with strobe low");
   ref_run_a: assert property (@(posedge link_clk_i) disable iff (rst_i) strobe_s ##1 strobe_s
      |-> bus_reference_clock_out_o != $past(bus_reference_clock_out_o))
      else $error("reference clock stalled");
endmodule : erw_top_chk

bind erw_top erw_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
   .bus_reference_clock_out_o(bus_reference_clock_out_o), .cs_n_o(cs_n_o),
   .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));

// ### test/test_erw_top.sv
module test_erw_top
   import erw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        link_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] q;
   logic [31:0] dat_o;
   logic        ack, ready, refc, cs_n, rd_n, wr_n;
   logic        pol = 1'b1;
   logic [3:0]  dly = 4'h0;
   int          fails = 0;
   int          n_checks = 0;
   initial forever #5 clk_i = !clk_i;
   initial begin
      #3;
      forever #16 link_clk_i = !link_clk_i;
   end
   erw_top u_erw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .link_clk_i(link_clk_i), .ready_i(ready),
      .bus_reference_clock_out_o(refc), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n));
   erw_ready_model u_erw_ready_model (.link_clk_i(link_clk_i), .ref_clk_i(refc),
      .strobe_n_i(rd_n & wr_n), .pol_hi_i(pol), .dly_i(dly), .ready_o(ready));
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      q = dat_o;
      cyc <= 1'b0;
      if (i == 50) begin
         fails++;
         final_report();
      end
   endtask : wb
   task run(input logic [11:0] c, input logic [3:0] dl, input logic [7:0] e);
      int i;
      dly <= dl;
      pol <= c[ERW_CTRL_POL_HI];
      wb(1'b1, ERW_ADR_CTRL, {20'h0, c});
      wb(1'b0, ERW_ADR_CTRL, 32'h0);
      chk(q, {20'h0, c});
      wb(1'b1, ERW_ADR_START, 32'h1);
      for (i = 0; i < 200; i++) begin
         wb(1'b0, ERW_ADR_STATUS, 32'h0);
         if (q[ERW_STAT_BUSY] === 1'b0) break;
      end
      if (i == 200) begin
         fails++;
         final_report();
      end
      chk({24'h0, q[15:8]}, {24'h0, e});
      $display("test ctrl %h delay %h done", c, dl);
   endtask : run
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ERW_ADR_CTRL, 32'h0);
      chk(q, {20'h0, ERW_CTRL_RESET});
      wb(1'b1, 4'hC, 32'hFFFF_FFFF);
      wb(1'b0, 4'hC, 32'h0);
      chk(q, 32'h0);
      repeat (20) @(posedge clk_i);
      run(12'h003, 4'h0, 8'h00);
      run(12'h001, 4'h0, 8'h00);
      run(12'h007, 4'h0, 8'h01);
      run(12'h003, 4'h3, 8'h03);
      run(12'h62B, 4'h0, 8'h00);
      run(12'h00F, 4'h2, 8'h03);
      run(12'h002, 4'hF, 8'h00);
      final_report();
   end
endmodule : test_erw_top
